// >>> bench/ucs_config_store_tb.sv
// Purpose: self-checking bench of the user set configuration store
// Assumes: one 100 MHz clock, axi4-lite master tasks, one access at a time
// Notes: drivers note expected responses in a queue, a monitor pops them
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, s); end end

module ucs_config_store_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ucs_pkg::*;
    logic ref_clk_i = 0, resetn_i = 0, nv_clear_i = 1, acq_busy = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, seq_value;
    logic [3:0] wstrb = 4'hf;
    logic [2:0] lut_idx = 0;
    logic awready, wready, bvalid, arready, rvalid, boot_done;
    logic [1:0] bresp, rresp;
    logic [11:0] lut_data;
    ucs_cfg_type active;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [31:0] scr[5];
    int fails = 0, checks = 0, i;
    localparam logic [7:0] IDO[7] = '{OFS_VENDOR, OFS_MODEL, OFS_VERSION,
        OFS_FW_VERSION, OFS_SERIAL, OFS_SCAN_TYPE, OFS_ARRAY_SIZE};
    localparam logic [31:0] IDV[7] = '{VENDOR_CODE, MODEL_CODE, VERSION_CODE,
        FW_CODE, SERIAL_CODE, SCAN_AREA, {ARRAY_ROWS, ARRAY_COLS}};
    // gain cfg words of the three factory sets
    localparam logic [31:0] FGAIN[3] = '{32'h0, 32'h6, 32'ha00};

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    ucs_config_store dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .nv_clear_i(nv_clear_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .acq_busy_i(acq_busy), .lut_idx_i(lut_idx),
        .lut_data_o(lut_data), .active_o(active), .seq_value_o(seq_value),
        .boot_done_o(boot_done));

    task print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    task tmo;
        fails++;
        print_verdict();
    endtask : tmo

    // first edge keeps a lowered bready or rready apart from the next raise
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        q.push_back({r, 32'h0});
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge ref_clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        bready <= 1'b0;
        if (k == 40) tmo();
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        q.push_back({r, d});
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge ref_clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        rready <= 1'b0;
        if (k == 40) tmo();
    endtask : rd

    task boot;
        int k;
        for (k = 0; k < 40 && boot_done !== 1'b1; k++) @(posedge ref_clk_i);
        if (k == 40) tmo();
    endtask : boot

    always @(posedge ref_clk_i) begin
        if (bvalid && bready) begin
            e = q.pop_front();
            `CHK("bresp", e[33:32], bresp)
        end
        if (rvalid && rready) begin
            e = q.pop_front();
            `CHK("rresp rdata", e, {rresp, rdata})
        end
    end

    initial begin
        void'($urandom(8037));
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        nv_clear_i <= 1'b0;
        boot();
        rd(OFS_SET_PICK, 32'h0, RESP_OKAY);
        rd(8'h50, 32'h0, RESP_SLVERR);
        for (i = 0; i < 7; i++) rd(IDO[i], IDV[i], RESP_OKAY);
        wr(OFS_VENDOR, 32'h1, RESP_SLVERR);
        wr(OFS_ARRAY_SIZE, 32'h1, RESP_SLVERR);
        rd(OFS_VENDOR, VENDOR_CODE, RESP_OKAY);
        wr(OFS_UNIT_NAME, 32'h434d_3031, RESP_OKAY);
        rd(OFS_UNIT_NAME, 32'h434d_3031, RESP_OKAY);
        // low byte only: the upper three bytes must survive the merge
        wstrb <= 4'h1;
        wr(OFS_UNIT_NAME, 32'hffff_ff55, RESP_OKAY);
        wstrb <= 4'hf;
        rd(OFS_UNIT_NAME, 32'h434d_3055, RESP_OKAY);
        for (i = 0; i < 5; i++) begin
            scr[i] = $urandom;
            wr(OFS_SCR_PICK, 32'(i), RESP_OKAY);
            wr(OFS_SCR_CONTENT, scr[i], RESP_OKAY);
        end
        for (i = 4; i >= 0; i--) begin
            wr(OFS_SCR_PICK, 32'(i), RESP_OKAY);
            rd(OFS_SCR_CONTENT, scr[i], RESP_OKAY);
        end
        rd(OFS_GAIN_CFG, 32'h0, RESP_OKAY);
        wr(OFS_REGION_OFS, 32'h0100_0020, RESP_OKAY);
        rd(OFS_REGION_LIM, 32'h0300_04e0, RESP_OKAY);
        wr(OFS_REGION_OFS, 32'h0500_0600, RESP_OKAY);
        rd(OFS_REGION_LIM, 32'h0, RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            wr(OFS_SET_PICK, 32'(i), RESP_OKAY);
            wr(OFS_CMD, 32'h2, RESP_OKAY);
            rd(OFS_GAIN_CFG, FGAIN[i], RESP_OKAY);
        end
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        rd(OFS_STATUS, 32'h3, RESP_OKAY);
        wr(OFS_CMD, 32'h2, RESP_OKAY);
        rd(OFS_GAIN_CFG, FGAIN[2], RESP_OKAY);
        wr(OFS_LUT_PICK, 32'h3, RESP_OKAY);
        wr(OFS_LUT_DATA, 32'habc, RESP_OKAY);
        wr(OFS_GAIN_CFG, 32'h415, RESP_OKAY);
        wr(OFS_SEQ_VALUE, 32'h5a5a_0001, RESP_OKAY);
        wr(OFS_SET_PICK, 32'h4, RESP_OKAY);
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        wr(OFS_GAIN_CFG, 32'h0, RESP_OKAY);
        wr(OFS_SEQ_VALUE, 32'h5a5a_0002, RESP_OKAY);
        wr(OFS_CMD, 32'h2, RESP_OKAY);
        rd(OFS_GAIN_CFG, 32'h415, RESP_OKAY);
        `CHK("seq_value", 32'h5a5a_0002, seq_value)
        rd(OFS_LUT_DATA, 32'habc, RESP_OKAY);
        // table port is registered: one edge to fetch, one to settle
        lut_idx <= 3'h3;
        repeat (2) @(posedge ref_clk_i);
        `CHK("lut_data", 12'habc, lut_data)
        acq_busy <= 1'b1;
        wr(OFS_SET_PICK, 32'h0, RESP_OKAY);
        wr(OFS_CMD, 32'h2, RESP_OKAY);
        rd(OFS_STATUS, 32'hd, RESP_OKAY);
        rd(OFS_GAIN_CFG, 32'h415, RESP_OKAY);
        wr(OFS_BOOT_PICK, 32'h4, RESP_OKAY);
        rd(OFS_BOOT_PICK, 32'h0, RESP_OKAY);
        acq_busy <= 1'b0;
        wr(OFS_BOOT_PICK, 32'h4, RESP_OKAY);
        rd(OFS_BOOT_PICK, 32'h4, RESP_OKAY);
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        boot();
        `CHK("active gain", 8'h15, active.gain)
        rd(OFS_GAIN_CFG, 32'h415, RESP_OKAY);
        rd(OFS_SCR_CONTENT, 32'h0, RESP_OKAY);
        rd(OFS_LUT_DATA, 32'h0, RESP_OKAY);
        `CHK("lut_data", 12'h0, lut_data)
        print_verdict();
    end
endmodule : ucs_config_store_tb

`default_nettype wire

// >>> core/ucs_config_store.sv
// Purpose: user set store with scratch bank and identity words
// Assumes: acq_busy_i and nv_clear_i come from ref_clk_i logic
// Notes: user slots and startup pick are reset only by nv_clear_i
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`default_nettype none

module ucs_config_store (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic nv_clear_i,
    // axi4-lite write channels
    input wire logic [ucs_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read channels
    input wire logic [ucs_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // camera side
    input wire logic acq_busy_i,
    input wire logic [ucs_pkg::LUT_IDX_W-1:0] lut_idx_i,
    output logic [ucs_pkg::LUT_W-1:0] lut_data_o,
    output ucs_pkg::ucs_cfg_type active_o,
    output logic [31:0] seq_value_o,
    output logic boot_done_o
);
    import ucs_pkg::*;

    ucs_state_type state_r;
    ucs_cfg_type active_r;
    ucs_cfg_type user_slot_r [NUM_USER];
    ucs_cfg_type boot_img;
    ucs_cfg_type pick_img;
    logic [2:0] set_pick_r;
    logic [2:0] boot_pick_r;
    logic [2:0] scr_pick_r;
    logic [31:0] scratch_r [NUM_SCRATCH];
    logic [31:0] unit_name_r;
    logic [31:0] seq_value_r;
    logic [LUT_W-1:0] lut_r [LUT_DEPTH];
    logic [LUT_IDX_W-1:0] lut_pick_r;
    logic [LUT_W-1:0] lut_data_r;
    logic save_rej_r;
    logic load_rej_r;
    // bus state
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic do_wr;
    logic [31:0] wval;
    logic idle_ok;
    logic cmd_save;
    logic cmd_load;
    logic save_ok;
    logic load_ok;
    logic boot_wr_ok;

    function automatic ucs_cfg_type set_image(input logic [2:0] idx);
        if (idx >= SET_USER1) begin
            return user_slot_r[2'(idx - SET_USER1)];
        end
        return ucs_factory(idx);
    endfunction : set_image

    // limit saturates at zero if an offset runs past the array
    function automatic logic [15:0] lim(input logic [15:0] full,
                                        input logic [15:0] ofs);
        return (ofs < full) ? 16'(full - ofs) : 16'h0000;
    endfunction : lim

    function automatic logic is_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_SCAN_TYPE);
    endfunction : is_mapped

    function automatic logic is_writable(input logic [7:0] a);
        return is_mapped(a) && (a != OFS_STATUS)
            && (a != OFS_REGION_LIM) && (a != OFS_ARRAY_SIZE)
            && (a < OFS_VENDOR);
    endfunction : is_writable

    function automatic logic [31:0] rd_val(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFS_SET_PICK: v[SET_W-1:0] = set_pick_r;
            OFS_BOOT_PICK: v[SET_W-1:0] = boot_pick_r;
            OFS_STATUS: begin
                v[STAT_IDLE_BIT] = (state_r == UCS_ST_IDLE);
                v[STAT_SAVE_REJ_BIT] = save_rej_r;
                v[STAT_LOAD_REJ_BIT] = load_rej_r;
                v[STAT_ACQ_BIT] = acq_busy_i;
            end
            OFS_GAIN_CFG: begin
                v[GAIN_LSB +: GAIN_W] = active_r.gain;
                v[GAIN_AUTO_LSB +: 2] = active_r.gain_auto;
                v[EXPO_AUTO_LSB +: 2] = active_r.expo_auto;
            end
            OFS_REGION_OFS: v = {active_r.vert, active_r.horiz};
            OFS_REGION_LIM: begin
                v = {lim(ARRAY_ROWS, active_r.vert),
                     lim(ARRAY_COLS, active_r.horiz)};
            end
            OFS_ARRAY_SIZE: v = {ARRAY_ROWS, ARRAY_COLS};
            OFS_SCR_PICK: v[2:0] = scr_pick_r;
            OFS_SCR_CONTENT: begin
                if (scr_pick_r <= SCR_LAST) begin
                    v = scratch_r[scr_pick_r];
                end
            end
            OFS_UNIT_NAME: v = unit_name_r;
            OFS_LUT_PICK: v[LUT_IDX_W-1:0] = lut_pick_r;
            OFS_LUT_DATA: v[LUT_W-1:0] = lut_r[lut_pick_r];
            OFS_SEQ_VALUE: v = seq_value_r;
            OFS_VENDOR: v = VENDOR_CODE;
            OFS_MODEL: v = MODEL_CODE;
            OFS_VERSION: v = VERSION_CODE;
            OFS_FW_VERSION: v = FW_CODE;
            OFS_SERIAL: v = SERIAL_CODE;
            OFS_SCAN_TYPE: v = SCAN_AREA;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : rd_val

    // byte strobes merge the new data into the current contents
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction : merge

    function automatic logic wr_hit(input logic [7:0] ofs);
        return do_wr && (awaddr_r == ofs);
    endfunction : wr_hit

    assign do_wr = aw_held_r && w_held_r;
    assign wval = merge(rd_val(awaddr_r), wdata_r, wstrb_r);
    assign boot_img = set_image(boot_pick_r);
    assign pick_img = set_image(set_pick_r);
    assign idle_ok = (state_r == UCS_ST_IDLE) && !acq_busy_i;
    assign cmd_save = wr_hit(OFS_CMD) && wstrb_r[0]
        && wdata_r[CMD_SAVE_BIT];
    assign cmd_load = wr_hit(OFS_CMD) && wstrb_r[0]
        && wdata_r[CMD_LOAD_BIT];
    assign save_ok = cmd_save && idle_ok
        && (set_pick_r >= SET_USER1);
    assign load_ok = cmd_load && idle_ok;
    assign boot_wr_ok = wr_hit(OFS_BOOT_PICK) && idle_ok
        && (wval[SET_W-1:0] <= SET_LAST);

    // bus handshakes
    assign s_axi_awready_o = !aw_held_r && !bvalid_r;
    assign s_axi_wready_o = !w_held_r && !bvalid_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    assign active_o = active_r;
    assign seq_value_o = seq_value_r;
    assign lut_data_o = lut_data_r;
    assign boot_done_o = (state_r == UCS_ST_IDLE);

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
            if (do_wr) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= is_writable(awaddr_r) ? RESP_OKAY
                                                 : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val(s_axi_araddr_i);
            rresp_r <= is_mapped(s_axi_araddr_i) ? RESP_OKAY
                                                 : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // active set: volatile, refilled from the startup set after reset
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_r <= UCS_ST_BOOT;
            active_r <= ucs_factory(SET_STD);
        end else begin
            case (state_r)
                UCS_ST_BOOT: begin
                    active_r <= boot_img;
                    state_r <= UCS_ST_IDLE;
                end
                UCS_ST_IDLE: begin
                    if (load_ok) begin
                        active_r <= pick_img;
                    end else if (wr_hit(OFS_GAIN_CFG)) begin
                        active_r.gain <= wval[GAIN_LSB +: GAIN_W];
                        active_r.gain_auto <=
                            ucs_auto_type'(wval[GAIN_AUTO_LSB +: 2]);
                        active_r.expo_auto <=
                            ucs_auto_type'(wval[EXPO_AUTO_LSB +: 2]);
                    end else if (wr_hit(OFS_REGION_OFS)) begin
                        active_r.horiz <= wval[15:0];
                        active_r.vert <= wval[VERT_LSB +: 16];
                    end
                end
                default: state_r <= UCS_ST_BOOT;
            endcase
        end
    end

    // stands in for non-volatile memory: device reset leaves it alone
    always_ff @(posedge ref_clk_i) begin
        if (nv_clear_i) begin
            for (int i = 0; i < NUM_USER; i++) begin
                user_slot_r[i] <= ucs_factory(SET_STD);
            end
            boot_pick_r <= SET_STD;
        end else begin
            if (save_ok) begin
                user_slot_r[2'(set_pick_r - SET_USER1)] <=
                    active_r;
            end
            if (boot_wr_ok) begin
                boot_pick_r <= wval[SET_W-1:0];
            end
        end
    end

    // selectors, refusal flags; a same-cycle reset beats a refusal
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            set_pick_r <= SET_STD;
            scr_pick_r <= 3'h0;
            lut_pick_r <= '0;
            save_rej_r <= 1'b0;
            load_rej_r <= 1'b0;
        end else begin
            if (wr_hit(OFS_SET_PICK) && wval[2:0] <= SET_LAST) begin
                set_pick_r <= wval[2:0];
            end
            if (wr_hit(OFS_SCR_PICK)) begin
                scr_pick_r <= wval[2:0];
            end
            if (wr_hit(OFS_LUT_PICK)) begin
                lut_pick_r <= wval[LUT_IDX_W-1:0];
            end
            if (cmd_save) begin
                save_rej_r <= !save_ok;
            end
            if (cmd_load) begin
                load_rej_r <= !load_ok;
            end
        end
    end

    // scratch bank is storage only; nothing else reads it
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NUM_SCRATCH; i++) begin
                scratch_r[i] <= 32'h0000_0000;
            end
        end else if (wr_hit(OFS_SCR_CONTENT) && scr_pick_r <= SCR_LAST) begin
            scratch_r[scr_pick_r] <= wval;
        end
    end

    // unit name and sequencer value are volatile and never saved
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            unit_name_r <= 32'h0000_0000;
            seq_value_r <= 32'h0000_0000;
        end else begin
            if (wr_hit(OFS_UNIT_NAME)) begin
                unit_name_r <= wval;
            end
            if (wr_hit(OFS_SEQ_VALUE)) begin
                seq_value_r <= wval;
            end
        end
    end

    // lookup table: cleared by reset, untouched by loads
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < LUT_DEPTH; i++) begin
                lut_r[i] <= '0;
            end
            lut_data_r <= '0;
        end else begin
            if (wr_hit(OFS_LUT_DATA)) begin
                lut_r[lut_pick_r] <= wval[LUT_W-1:0];
            end
            lut_data_r <= lut_r[lut_idx_i];
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_SCRATCH_BACK: assert property (
        wr_hit(OFS_SCR_CONTENT) && scr_pick_r <= SCR_LAST
            && wstrb_r == 4'hf
        |=> scratch_r[$past(scr_pick_r)] == $past(wdata_r))
        else $error("scratch value not stored");

    AST_SCRATCH_READ: assert property (
        s_axi_arvalid_i && s_axi_arready_o
            && s_axi_araddr_i == OFS_SCR_CONTENT && scr_pick_r <= SCR_LAST
        |=> rvalid_r && rdata_r == $past(scratch_r[scr_pick_r]))
        else $error("scratch read returned wrong entry");

    AST_RO_REFUSED: assert property (
        do_wr && awaddr_r >= OFS_VENDOR && is_mapped(awaddr_r)
        |=> bvalid_r && bresp_r == RESP_SLVERR)
        else $error("identity write not refused");

    AST_LIMIT_TRACK: assert property (
        wr_hit(OFS_REGION_OFS) && wstrb_r == 4'hf && idle_ok && !load_ok
            && wdata_r[15:0] < ARRAY_COLS
        |=> lim(ARRAY_COLS, active_r.horiz)
            == 16'(ARRAY_COLS - $past(wdata_r[15:0])))
        else $error("region limit not recomputed");

    AST_BOOT_COPY: assert property (
        state_r == UCS_ST_BOOT
        |=> state_r == UCS_ST_IDLE && active_r == $past(boot_img))
        else $error("startup set not copied");

    AST_LOAD_COPY: assert property (
        load_ok |=> active_r == $past(pick_img))
        else $error("load did not copy selected set");

    AST_SAVE_COPY: assert property (
        save_ok |=> user_slot_r[$past(2'(set_pick_r - SET_USER1))]
            == $past(active_r))
        else $error("save did not overwrite slot");

    AST_SAVE_REJECT: assert property (
        cmd_save && (set_pick_r < SET_USER1 || acq_busy_i)
        |=> save_rej_r)
        else $error("forbidden save not flagged");

    AST_LUT_KEPT: assert property (
        load_ok |=> lut_r[lut_pick_r] == $past(lut_r[lut_pick_r]))
        else $error("load disturbed lookup table");

    AST_PICK_RESET: assert property (
        disable iff (1'b0) !resetn_i |=> set_pick_r == SET_STD)
        else $error("set selector not at standard after reset");

    COV_BOOT: cover property (state_r == UCS_ST_BOOT ##1 boot_done_o);
    COV_SAVE: cover property (save_ok);
    COV_LOAD_USER: cover property (load_ok && set_pick_r >= SET_USER1);
    COV_SAVE_REJ: cover property (cmd_save && !save_ok);
endmodule : ucs_config_store

`default_nettype wire

// >>> core/ucs_pkg.sv
// Purpose: constants and types of the user set configuration store
// Assumes: AXI4-Lite slave, 32-bit words, 100 MHz ref clock
// Notes: offsets are byte addresses; identity codes are arbitrary
`default_nettype none

package ucs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_SET_PICK = 8'h04;
    localparam logic [7:0] OFS_BOOT_PICK = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_GAIN_CFG = 8'h10;
    localparam logic [7:0] OFS_REGION_OFS = 8'h14;
    localparam logic [7:0] OFS_REGION_LIM = 8'h18;
    localparam logic [7:0] OFS_ARRAY_SIZE = 8'h1c;
    localparam logic [7:0] OFS_SCR_PICK = 8'h20;
    localparam logic [7:0] OFS_SCR_CONTENT = 8'h24;
    localparam logic [7:0] OFS_UNIT_NAME = 8'h28;
    localparam logic [7:0] OFS_LUT_PICK = 8'h2c;
    localparam logic [7:0] OFS_LUT_DATA = 8'h30;
    localparam logic [7:0] OFS_SEQ_VALUE = 8'h34;
    localparam logic [7:0] OFS_VENDOR = 8'h38;
    localparam logic [7:0] OFS_MODEL = 8'h3c;
    localparam logic [7:0] OFS_VERSION = 8'h40;
    localparam logic [7:0] OFS_FW_VERSION = 8'h44;
    localparam logic [7:0] OFS_SERIAL = 8'h48;
    localparam logic [7:0] OFS_SCAN_TYPE = 8'h4c;
    // field positions
    localparam int CMD_SAVE_BIT = 0;
    localparam int CMD_LOAD_BIT = 1;
    localparam int STAT_IDLE_BIT = 0;
    localparam int STAT_SAVE_REJ_BIT = 1;
    localparam int STAT_LOAD_REJ_BIT = 2;
    localparam int STAT_ACQ_BIT = 3;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_AUTO_LSB = 8;
    localparam int EXPO_AUTO_LSB = 10;
    localparam int VERT_LSB = 16;
    // set numbering: three factory sets, then three user slots
    localparam int SET_W = 3;
    localparam logic [2:0] SET_STD = 3'h0;
    localparam logic [2:0] SET_HIGAIN = 3'h1;
    localparam logic [2:0] SET_AUTO = 3'h2;
    localparam logic [2:0] SET_USER1 = 3'h3;
    localparam logic [2:0] SET_LAST = 3'h5;
    localparam int NUM_USER = 3;
    localparam int NUM_SCRATCH = 5;
    localparam logic [2:0] SCR_LAST = 3'h4;
    localparam int LUT_DEPTH = 8;
    localparam int LUT_IDX_W = 3;
    localparam int LUT_W = 12;
    // gain in whole dB
    localparam int GAIN_W = 8;
    localparam logic [7:0] GAIN_LOW_DB = 8'h00;
    localparam logic [7:0] GAIN_HIGH_STEP_DB = 8'h06;
    localparam logic [15:0] ARRAY_COLS = 16'h0500;
    localparam logic [15:0] ARRAY_ROWS = 16'h0400;
    // identity words, values arbitrary
    localparam logic [31:0] VENDOR_CODE = 32'h0000_0a01;
    localparam logic [31:0] MODEL_CODE = 32'h0000_0b02;
    localparam logic [31:0] VERSION_CODE = 32'h0000_0103;
    localparam logic [31:0] FW_CODE = 32'h0000_0204;
    localparam logic [31:0] SERIAL_CODE = 32'h0000_3005;
    localparam logic [31:0] SCAN_AREA = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        UCS_AUTO_OFF = 2'h0,
        UCS_AUTO_ONCE = 2'h1,
        UCS_AUTO_CONT = 2'h2
    } ucs_auto_type;

    typedef enum logic [1:0] {
        UCS_ST_BOOT = 2'h1,
        UCS_ST_IDLE = 2'h2
    } ucs_state_type;

    // saved part of the active set; table and sequencer stay outside
    typedef struct packed {
        logic [7:0] gain;
        ucs_auto_type gain_auto;
        ucs_auto_type expo_auto;
        logic [15:0] horiz;
        logic [15:0] vert;
    } ucs_cfg_type;

    // factory sets are constants, so nothing can overwrite them
    function automatic ucs_cfg_type ucs_factory(input logic [2:0] idx);
        ucs_cfg_type c;
        c.gain = GAIN_LOW_DB;
        c.gain_auto = UCS_AUTO_OFF;
        c.expo_auto = UCS_AUTO_OFF;
        c.horiz = 16'h0000;
        c.vert = 16'h0000;
        if (idx == SET_HIGAIN) begin
            c.gain = GAIN_LOW_DB + GAIN_HIGH_STEP_DB;
        end
        if (idx == SET_AUTO) begin
            c.gain_auto = UCS_AUTO_CONT;
            c.expo_auto = UCS_AUTO_CONT;
        end
        return c;
    endfunction : ucs_factory
endpackage : ucs_pkg

`default_nettype wire
